// *** bs_agc_config.sv ***
// bit-sync and gain-control configuration registers behind a serial port
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - after sync, bit 3 picks pre-sync integral gain (0) or half the base integral gain (1), reset 1.
// - after sync, bit 2 picks pre-sync proportional gain (0) or the base proportional gain (1), reset 1.
// - bits 1:0 clamp rate offset compensation to 3.125, 6.25 or 12.5 percent for codes 1 to 3.
// - code 00 in bits 1:0, the reset value, turns rate offset compensation off.
// - bits 7:6 of the gain register bar that many of the top digital gain steps, reset 0.
// - bits 5:3 cap the front-end gain, code 0 full, codes 1 to 7 lower it, reset 0.
// - bits 2:0 pick the amplitude target 24 to 42 dB, reset code 3.
// - before sync, bits 7:6 pick one to four times the base integral gain, reset 1.
module bs_agc_config #(
   parameter int SPI_ADDR_WIDTH = 6
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // serial port pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso_out,
   output logic spi_miso_oe,
   // receive events
   input wire logic rx_start,
   input wire logic sync_detected,
   // clock recovery controls
   output logic [3:0] ki_half,
   output logic [3:0] kp_half,
   output logic post_sync_active,
   output logic rate_comp_en,
   output logic [1:0] rate_offset_saturation,
   // gain controller controls
   output logic [1:0] digital_gain_ceiling,
   output logic [2:0] front_end_gain_ceiling,
   output logic [5:0] amplitude_target_db
);
   import bs_agc_pkg::*;

   if (SPI_ADDR_WIDTH != 6) begin : g_bad_width
      $error("header carries a six-bit address");
   end

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] cs_s;
      logic [2:0] mosi_s;
      logic sclk_f;
      logic cs_n_f;
      logic mosi_f;
      logic [4:0] bit_cnt;
      logic [7:0] shift;
      logic is_read;
      logic [5:0] addr;
      logic [7:0] tx;
      logic miso;
      logic miso_oe;
      logic [7:0] bs_cfg;
      logic [7:0] agc_cfg;
      logic rate_en;
      logic [1:0] limit;
      logic [1:0] dvga;
      logic [2:0] lna;
      logic [5:0] target;
   } cfg_state_type;

   cfg_state_type q;
   cfg_state_type n;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] shift_in;
   logic [7:0] rd_data;
   logic wr_bs;
   logic wr_agc;

   always_comb begin
      n = q;
      wr_bs = 1'b0;
      wr_agc = 1'b0;
      rd_data = 8'h00;
      // index 0 is the first stage, read only by stage 1
      n.sclk_s = {q.sclk_s[1:0], spi_sclk};
      n.cs_s = {q.cs_s[1:0], spi_cs_n};
      n.mosi_s = {q.mosi_s[1:0], spi_mosi};
      if (q.sclk_s[1] == q.sclk_s[2]) begin
         n.sclk_f = q.sclk_s[2];
      end
      if (q.cs_s[1] == q.cs_s[2]) begin
         n.cs_n_f = q.cs_s[2];
      end
      if (q.mosi_s[1] == q.mosi_s[2]) begin
         n.mosi_f = q.mosi_s[2];
      end
      sclk_rise = n.sclk_f && !q.sclk_f;
      sclk_fall = !n.sclk_f && q.sclk_f;
      shift_in = {q.shift[6:0], q.mosi_f};
      unique case (shift_in[5:0])
         BS_CFG_ADDR: rd_data = q.bs_cfg;
         AGC_CFG_ADDR: rd_data = q.agc_cfg;
         default: rd_data = 8'h00;
      endcase
      if (n.cs_n_f) begin
         // deselect aborts any half-done frame; nothing is written
         // acting on the next value drops miso in step with its enable
         n.bit_cnt = 5'h00;
         n.miso = 1'b0;
      end else if (sclk_rise && q.bit_cnt < FRAME_BITS) begin
         n.shift = shift_in;
         n.bit_cnt = q.bit_cnt + 5'h01;
         if (q.bit_cnt == HDR_LAST_BIT) begin
            n.is_read = shift_in[READ_FLAG_BIT];
            n.addr = shift_in[5:0];
            n.tx = rd_data;
         end
         if (q.bit_cnt == FRAME_LAST_BIT && !q.is_read) begin
            // unmapped addresses drop the write
            wr_bs = (q.addr == BS_CFG_ADDR);
            wr_agc = (q.addr == AGC_CFG_ADDR);
         end
      end else if (sclk_fall && q.bit_cnt >= HDR_BITS && q.bit_cnt < FRAME_BITS) begin
         n.miso = q.tx[7];
         n.tx = {q.tx[6:0], 1'b0};
      end
      if (wr_bs) begin
         n.bs_cfg = shift_in;
      end
      if (wr_agc) begin
         n.agc_cfg = shift_in;
      end
      n.miso_oe = !n.cs_n_f;
      n.limit = n.bs_cfg[LIMIT_LSB +: 2];
      n.rate_en = (n.bs_cfg[LIMIT_LSB +: 2] != 2'h0);
      n.dvga = n.agc_cfg[DVGA_LSB +: 2];
      n.lna = n.agc_cfg[LNA_LSB +: 3];
      n.target = TARGET_DB_TABLE[n.agc_cfg[TARGET_LSB +: 3]];
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
         q.cs_s <= 3'h7;
         q.cs_n_f <= 1'b1;
         q.bs_cfg <= BS_CFG_RESET;
         q.agc_cfg <= AGC_CFG_RESET;
         q.target <= TARGET_DB_TABLE[AGC_CFG_RESET[TARGET_LSB +: 3]];
      end else begin
         q <= n;
      end
   end

   loop_gain_select u_gain (
      .core_clk(core_clk),
      .reset(reset),
      .rx_start(rx_start),
      .sync_detected(sync_detected),
      .pre_sync_integral_gain_sel(q.bs_cfg[PRE_KI_LSB +: 2]),
      .pre_sync_proportional_gain_sel(q.bs_cfg[PRE_KP_LSB +: 2]),
      .post_sync_integral_gain_sel(q.bs_cfg[POST_KI_BIT]),
      .post_sync_proportional_gain_sel(q.bs_cfg[POST_KP_BIT]),
      .ki_half(ki_half),
      .kp_half(kp_half),
      .post_sync_active(post_sync_active)
   );

   assign spi_miso_out = q.miso;
   assign spi_miso_oe = q.miso_oe;
   assign rate_comp_en = q.rate_en;
   assign rate_offset_saturation = q.limit;
   assign digital_gain_ceiling = q.dvga;
   assign front_end_gain_ceiling = q.lna;
   assign amplitude_target_db = q.target;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   property p_no_comp_at_zero;
      q.bs_cfg[LIMIT_LSB +: 2] == 2'h0 |-> !rate_comp_en;
   endproperty
   a_no_comp_at_zero: assert property (p_no_comp_at_zero)
      else $error("rate compensation enabled with zero limit");

   property p_limit_follows;
      $changed(q.bs_cfg) |-> rate_offset_saturation == q.bs_cfg[1:0]
         && rate_comp_en == (q.bs_cfg[1:0] != 2'h0);
   endproperty
   a_limit_follows: assert property (p_limit_follows)
      else $error("rate limit output does not follow register");

   property p_dvga;
      digital_gain_ceiling == q.agc_cfg[7:6];
   endproperty
   a_dvga: assert property (p_dvga)
      else $error("digital gain ceiling mismatch");

   property p_lna;
      $changed(q.agc_cfg) |-> front_end_gain_ceiling == q.agc_cfg[5:3];
   endproperty
   a_lna: assert property (p_lna)
      else $error("front-end gain ceiling mismatch");

   property p_target;
      amplitude_target_db >= 6'h18 && amplitude_target_db <= 6'h2A
         && amplitude_target_db == TARGET_DB_TABLE[q.agc_cfg[2:0]];
   endproperty
   a_target: assert property (p_target)
      else $error("amplitude target off its table");

   property p_write_cause;
      $changed(q.bs_cfg) |-> !$past(q.is_read) && $past(q.bit_cnt) == FRAME_LAST_BIT
         && $past(q.addr) == BS_CFG_ADDR && !$past(q.cs_n_f);
   endproperty
   a_write_cause: assert property (p_write_cause)
      else $error("loop config changed without a write frame");

   property p_miso_quiet;
      !spi_miso_oe |-> !spi_miso_out;
   endproperty
   a_miso_quiet: assert property (p_miso_quiet)
      else $error("serial output active while deselected");
endmodule : bs_agc_config
`default_nettype wire

// *** bs_agc_pkg.sv ***
// shared constants for the bit-sync and gain-control configuration block
package bs_agc_pkg;
   // register addresses on the serial port
   localparam logic [5:0] BS_CFG_ADDR = 6'h1A;
   localparam logic [5:0] AGC_CFG_ADDR = 6'h1B;
   // reset values
   localparam logic [7:0] BS_CFG_RESET = 8'h6C;
   localparam logic [7:0] AGC_CFG_RESET = 8'h03;
   // bit_sync_loop_config fields
   localparam int PRE_KI_LSB = 6;
   localparam int PRE_KP_LSB = 4;
   localparam int POST_KI_BIT = 3;
   localparam int POST_KP_BIT = 2;
   localparam int LIMIT_LSB = 0;
   // agc_limits_and_target fields
   localparam int DVGA_LSB = 6;
   localparam int LNA_LSB = 3;
   localparam int TARGET_LSB = 0;
   // serial frame layout
   localparam int READ_FLAG_BIT = 7;
   localparam logic [4:0] HDR_LAST_BIT = 5'h07;
   localparam logic [4:0] HDR_BITS = 5'h08;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   // amplitude target in dB, indexed by code
   localparam logic [7:0][5:0] TARGET_DB_TABLE = {
      6'h2A, 6'h28, 6'h26, 6'h24, 6'h21, 6'h1E, 6'h1B, 6'h18};
   // loop gains are given in half-K units
   localparam logic [3:0] HALF_K = 4'h1;
   localparam logic [3:0] ONE_K = 4'h2;
endpackage : bs_agc_pkg

// *** loop_gain_select.sv ***
// clock recovery loop gain selection across the sync word boundary
`timescale 1ns/1ns
`default_nettype none
module loop_gain_select (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // receive events
   input wire logic rx_start,
   input wire logic sync_detected,
   // configuration
   input wire logic [1:0] pre_sync_integral_gain_sel,
   input wire logic [1:0] pre_sync_proportional_gain_sel,
   input wire logic post_sync_integral_gain_sel,
   input wire logic post_sync_proportional_gain_sel,
   // gains in half-K units
   output logic [3:0] ki_half,
   output logic [3:0] kp_half,
   output logic post_sync_active
);
   import bs_agc_pkg::*;

   typedef struct packed {
      logic post;
      logic [3:0] ki;
      logic [3:0] kp;
   } gain_state_type;

   gain_state_type q;
   gain_state_type n;
   logic [3:0] pre_ki;
   logic [3:0] pre_kp;

   always_comb begin
      n = q;
      // code c gives (c+1) K, i.e. 2(c+1) halves
      pre_ki = {1'b0, pre_sync_integral_gain_sel, 1'b0} + ONE_K;
      pre_kp = {1'b0, pre_sync_proportional_gain_sel, 1'b0} + ONE_K;
      // sync wins over a coincident restart: the frame already locked
      if (sync_detected) begin
         n.post = 1'b1;
      end else if (rx_start) begin
         n.post = 1'b0;
      end
      n.ki = (n.post && post_sync_integral_gain_sel) ? HALF_K : pre_ki;
      n.kp = (n.post && post_sync_proportional_gain_sel) ? ONE_K : pre_kp;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q.post <= 1'b0;
         q.ki <= {1'b0, BS_CFG_RESET[PRE_KI_LSB +: 2], 1'b0} + ONE_K;
         q.kp <= {1'b0, BS_CFG_RESET[PRE_KP_LSB +: 2], 1'b0} + ONE_K;
      end else begin
         q <= n;
      end
   end

   assign ki_half = q.ki;
   assign kp_half = q.kp;
   assign post_sync_active = q.post;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_sync_seen;
      sync_detected ##1 post_sync_active;
   endsequence

   property p_sync_switches;
      sync_detected |-> s_sync_seen;
   endproperty
   a_sync_switches: assert property (p_sync_switches)
      else $error("post-sync mode not entered after sync");

   property p_start_restores;
      rx_start && !sync_detected |=> !post_sync_active ##0 ki_half == $past(pre_ki);
   endproperty
   a_start_restores: assert property (p_start_restores)
      else $error("pre-sync gains not restored on new reception");

   property p_post_ki;
      post_sync_active && $past(post_sync_integral_gain_sel) |-> ki_half == HALF_K;
   endproperty
   a_post_ki: assert property (p_post_ki)
      else $error("post-sync integral gain is not half K");

   property p_post_kp;
      post_sync_active && !$past(post_sync_proportional_gain_sel)
         |-> kp_half == $past(pre_kp);
   endproperty
   a_post_kp: assert property (p_post_kp)
      else $error("post-sync proportional gain does not keep pre-sync value");

   property p_pre_ki;
      !post_sync_active |-> ki_half == {1'b0, $past(pre_sync_integral_gain_sel), 1'b0} + ONE_K;
   endproperty
   a_pre_ki: assert property (p_pre_ki)
      else $error("pre-sync integral gain wrong for its code");
endmodule : loop_gain_select
`default_nettype wire

// *** spi_host.sv ***
// serial host model driving the configuration port
`timescale 1ns/1ns
`default_nettype none
module spi_host (
   // clock
   input wire logic core_clk,
   // serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // five cycles per level keeps each level above the sampling filter
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd,
         output logic [7:0] rd);
      logic [15:0] sh;
      sh = {hdr, wd};
      rd = 8'h00;
      @(posedge core_clk);
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi <= sh[i];
         wt(5);
         if (i < 8) rd = {rd[6:0], spi_miso};
         spi_sclk <= 1'b1;
         wt(5);
         spi_sclk <= 1'b0;
      end
      wt(5);
      spi_cs_n <= 1'b1;
      // released data line shows no stale value
      spi_mosi <= ~spi_mosi;
      wt(8);
   endtask : xfer
endmodule : spi_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import bs_agc_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, rx_start = 1'b0, sync_detected = 1'b0;
   logic spi_sclk, spi_cs_n, spi_mosi, miso_out, miso_oe, post_act, comp_en;
   logic [3:0] ki_half, kp_half, pk, pp;
   logic [1:0] sat, dvga;
   logic [2:0] lna;
   logic [5:0] tgt;
   logic [7:0] v, rd, rd_seen;
   logic rd_valid = 1'b0;
   logic [7:0] exp_q[$];
   int err_total = 0, n_compared = 0, cycles = 0;
   localparam logic [5:0] DB [8] = '{6'h18, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A};
   bs_agc_config #(.SPI_ADDR_WIDTH(6)) i_bs_agc_config (.core_clk(core_clk), .reset(reset),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso_out(miso_out), .spi_miso_oe(miso_oe), .rx_start(rx_start),
      .sync_detected(sync_detected), .ki_half(ki_half), .kp_half(kp_half),
      .post_sync_active(post_act), .rate_comp_en(comp_en), .rate_offset_saturation(sat),
      .digital_gain_ceiling(dvga), .front_end_gain_ceiling(lna), .amplitude_target_db(tgt));
   // undriven line reads as the inverse so a stale bit cannot pass
   spi_host i_spi_host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(miso_oe ? miso_out : ~miso_out));
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_spi_host.xfer({2'b00, a}, d, rd);
      @(negedge core_clk);
   endtask : wr
   task automatic rdq(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_spi_host.xfer({2'b10, a}, 8'($urandom), rd_seen);
      rd_valid <= 1'b1;
      @(posedge core_clk);
      rd_valid <= 1'b0;
   endtask : rdq
   task automatic pulse(input logic s, input logic r);
      @(posedge core_clk);
      sync_detected <= s;
      rx_start <= r;
      @(posedge core_clk);
      sync_detected <= 1'b0;
      rx_start <= 1'b0;
      @(negedge core_clk);
   endtask : pulse
   always @(posedge core_clk) begin
      if (rd_valid === 1'b1) check("read", rd_seen, exp_q.pop_front());
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'hD5AB77A7));
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (5) @(negedge core_clk);
      check("ki", ki_half, 8'h04);
      check("kp", kp_half, 8'h06);
      check("post", post_act, 8'h00);
      check("comp_en", comp_en, 8'h00);
      check("dvga", dvga, 8'h00);
      check("lna", lna, 8'h00);
      check("target", tgt, 8'h21);
      rdq(BS_CFG_ADDR, 8'h6C);
      rdq(AGC_CFG_ADDR, 8'h03);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         v = {c[1:0], 3'(7 - c), c[2:0]};
         wr(AGC_CFG_ADDR, v);
         check("target", tgt, DB[c]);
         check("dvga", dvga, v[7:6]);
         check("lna", lna, v[5:3]);
         rdq(AGC_CFG_ADDR, v);
      end
      $display("test gain control done");
      for (int i = 0; i < 8; i++) begin
         v = {4'($urandom), i[2:1], i[1:0]};
         pk = 4'(2 * (v[7:6] + 1));
         pp = 4'(2 * (v[5:4] + 1));
         wr(BS_CFG_ADDR, v);
         check("comp_en", comp_en, v[1:0] != 2'h0);
         check("sat", sat, v[1:0]);
         pulse(1'b0, 1'b1);
         check("post", post_act, 8'h00);
         check("ki", ki_half, pk);
         check("kp", kp_half, pp);
         pulse(1'b1, i[0]);
         check("post", post_act, 8'h01);
         check("ki", ki_half, v[3] ? 4'h1 : pk);
         check("kp", kp_half, v[2] ? 4'h2 : pp);
         rdq(BS_CFG_ADDR, v);
      end
      $display("test loop gains done");
      wr(6'h05, 8'hFF);
      rdq(6'h05, 8'h00);
      rdq(AGC_CFG_ADDR, 8'hC7);
      $display("test unmapped done");
      repeat (4) @(posedge core_clk);
      stop_test();
   end
endmodule : tb
`default_nettype wire
